// *** design/dmsic_core.sv ***
// data-side core: mapped data memory, pointers, status and interrupt control
`timescale 1ns/1ps
`default_nettype none
module dmsic_core (
	input wire logic clk_in,
	input wire logic rst_n_in,
	// data access from the execute stage
	input wire logic [7:0] addr_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out,
	// bit set/clear on the addressed byte
	input wire logic bit_op_in,
	input wire logic [2:0] bit_sel_in,
	input wire logic bit_val_in,
	// arithmetic unit: operand a is the addressed byte, b is the working register
	input wire logic alu_in,
	input wire dmsic_pkg::dmsic_op_t alu_op_in,
	input wire logic alu_to_mem_in,
	output logic zero_out,
	// working register load and fixed-value sources
	input wire logic work_load_in,
	input wire logic [7:0] work_data_in,
	output logic [7:0] work_register_out,
	// display segment memory reached by pointer 1
	output logic disp_wr_out,
	output logic [7:0] disp_addr_out,
	output logic [7:0] disp_wdata_out,
	input wire logic [7:0] disp_rdata_in,
	// power and watchdog events
	input wire logic halt_op_in,
	input wire logic dog_clear_op_in,
	input wire logic dog_timeout_in,
	output logic halted_out,
	// return stack and interrupt handshake
	input wire logic [2:0] stack_depth_in,
	input wire logic irq_return_op_in,
	input wire logic sub_return_op_in,
	input wire logic ack_ready_in,
	output logic ack_out,
	output logic [10:0] vector_out,
	output logic wake_out,
	// request sources
	input wire logic ext_irq_n_in,
	input wire logic tb_tick_in,
	input wire logic rtc_tick_in,
	input wire logic tmr_tick_in,
	// lookup high byte loaded by table reads
	input wire logic lookup_load_in,
	input wire logic [7:0] lookup_data_in
);
	logic [7:0] gp_mem [dmsic_pkg::GP_DEPTH];
	logic [7:0] mem_pointer_0;
	logic [7:0] mem_pointer_1;
	logic [7:0] work_register;
	logic [7:0] flags_register;
	logic [7:0] irq_control_0;
	logic [7:0] irq_control_1;
	logic [7:0] lookup_high_byte;
	logic [7:0] plain_regs [7];
	logic ext_s1;
	logic ext_s2;
	logic ext_s3;
	logic [7:0] eff_addr;
	logic via_p1;
	logic blocked;
	logic is_disp;
	logic [7:0] cur_byte;
	logic [7:0] next_byte;
	logic do_write;
	logic [7:0] alu_res;
	logic [3:0] alu_flags;
	logic alu_arith;
	logic [3:0] pend;
	logic ack;
	logic [10:0] next_vector;
	logic ext_fall;

	// index of the passive registers kept as plain storage
	function automatic logic [2:0] plain_index(input logic [7:0] a);
		if (a == dmsic_pkg::ADDR_BANK_SELECT)
			plain_index = 3'd0;
		else if (a == dmsic_pkg::ADDR_PROG_COUNT_LOW)
			plain_index = 3'd1;
		else if (a == dmsic_pkg::ADDR_LOOKUP_POINTER)
			plain_index = 3'd2;
		else if (a == dmsic_pkg::ADDR_CLOCK_TICK_CONTROL)
			plain_index = 3'd3;
		else if (a == dmsic_pkg::ADDR_IO_PORT_A)
			plain_index = 3'd4;
		else if (a == dmsic_pkg::ADDR_IO_PORT_B)
			plain_index = 3'd5;
		else if (a == dmsic_pkg::ADDR_RC_CONVERTER_CONTROL)
			plain_index = 3'd6;
		else
			plain_index = 3'd7;
	endfunction : plain_index

	function automatic logic is_gp(input logic [7:0] a);
		is_gp = (a >= dmsic_pkg::ADDR_GP_FIRST) && (a <= dmsic_pkg::ADDR_GP_LAST);
	endfunction : is_gp

	// indirect slots resolve through the matching pointer
	always_comb
	begin
		via_p1 = (addr_in == dmsic_pkg::ADDR_INDIRECT_1);
		eff_addr = addr_in;
		if (addr_in == dmsic_pkg::ADDR_INDIRECT_0)
			eff_addr = mem_pointer_0;
		else if (via_p1)
			eff_addr = mem_pointer_1;
		// pointer aimed at a slot reads zero and writes nothing
		blocked = (addr_in == dmsic_pkg::ADDR_INDIRECT_0 || via_p1)
			&& (eff_addr == dmsic_pkg::ADDR_INDIRECT_0
			|| eff_addr == dmsic_pkg::ADDR_INDIRECT_1);
		// only pointer 1 reaches display memory
		is_disp = via_p1 && mem_pointer_1[7];
	end

	assign disp_addr_out = {1'b0, mem_pointer_1[6:0]};

	// read decode; unmapped reserved space returns zero
	always_comb
	begin
		cur_byte = dmsic_pkg::RESET_BYTE;
		if (blocked)
			cur_byte = dmsic_pkg::RESET_BYTE;
		else if (is_disp)
			cur_byte = disp_rdata_in;
		else if (is_gp(eff_addr))
			cur_byte = gp_mem[eff_addr[5:0]];
		else if (eff_addr == dmsic_pkg::ADDR_MEM_POINTER_0)
			cur_byte = mem_pointer_0;
		else if (eff_addr == dmsic_pkg::ADDR_MEM_POINTER_1)
			cur_byte = mem_pointer_1;
		else if (eff_addr == dmsic_pkg::ADDR_WORK_REGISTER)
			cur_byte = work_register;
		else if (eff_addr == dmsic_pkg::ADDR_FLAGS_REGISTER)
			cur_byte = {2'b00, flags_register[5:0]};
		else if (eff_addr == dmsic_pkg::ADDR_IRQ_CONTROL_0)
			cur_byte = irq_control_0 & dmsic_pkg::IRQ0_MASK;
		else if (eff_addr == dmsic_pkg::ADDR_IRQ_CONTROL_1)
			cur_byte = irq_control_1 & dmsic_pkg::IRQ1_MASK;
		else if (eff_addr == dmsic_pkg::ADDR_LOOKUP_HIGH_BYTE)
			cur_byte = lookup_high_byte;
		else if (plain_index(eff_addr) != 3'd7)
			cur_byte = plain_regs[plain_index(eff_addr)];
		else
			cur_byte = dmsic_pkg::RESET_BYTE;
	end

	dmsic_alu u_alu (
		.op_in(alu_op_in),
		.a_in(cur_byte),
		.b_in(work_register),
		.carry_in(flags_register[dmsic_pkg::FLAG_CARRY]),
		.flags_in(flags_register[3:0]),
		.result_out(alu_res),
		.flags_out(alu_flags),
		.arith_out(alu_arith)
	);

	// byte to store: plain write, bit edit or unit result
	always_comb
	begin
		next_byte = wdata_in;
		do_write = 1'b0;
		if (bit_op_in)
		begin
			next_byte = cur_byte;
			next_byte[bit_sel_in] = bit_val_in;
			do_write = 1'b1;
		end
		else if (alu_in && alu_to_mem_in)
		begin
			next_byte = alu_res;
			do_write = 1'b1;
		end
		else if (wr_in)
			do_write = 1'b1;
		// a blocked indirect write stores nothing; a unit result still updates flags bits 3:0
		if (blocked)
			do_write = 1'b0;
	end

	assign disp_wr_out = do_write && is_disp;
	assign disp_wdata_out = next_byte;

	// general purpose storage
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			for (int i = 0; i < dmsic_pkg::GP_DEPTH; i++)
				gp_mem[i] <= dmsic_pkg::RESET_BYTE;
		end
		else if (do_write && !is_disp && is_gp(eff_addr))
			gp_mem[eff_addr[5:0]] <= next_byte;
	end

	// pointers and passive registers; reserved writes fall through unused
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			mem_pointer_0 <= dmsic_pkg::RESET_BYTE;
			mem_pointer_1 <= dmsic_pkg::RESET_BYTE;
			for (int i = 0; i < 7; i++)
				plain_regs[i] <= dmsic_pkg::RESET_BYTE;
		end
		else if (do_write && !is_disp)
		begin
			if (eff_addr == dmsic_pkg::ADDR_MEM_POINTER_0)
				mem_pointer_0 <= next_byte;
			else if (eff_addr == dmsic_pkg::ADDR_MEM_POINTER_1)
				mem_pointer_1 <= next_byte;
			else if (plain_index(eff_addr) != 3'd7)
				plain_regs[plain_index(eff_addr)] <= next_byte;
		end
	end

	// read-only lookup byte, loaded only by the table read path
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			lookup_high_byte <= dmsic_pkg::RESET_BYTE;
		else if (lookup_load_in)
			lookup_high_byte <= lookup_data_in;
	end

	// working register: direct load, unit result or mapped write
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			work_register <= dmsic_pkg::RESET_BYTE;
		else if (do_write && !is_disp && eff_addr == dmsic_pkg::ADDR_WORK_REGISTER)
			work_register <= next_byte;
		else if (alu_in && !alu_to_mem_in)
			work_register <= alu_res;
		else if (work_load_in)
			work_register <= work_data_in;
	end

	// status flags; a mapped write beats the unit result and software cannot touch bits 4-5
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			flags_register <= dmsic_pkg::RESET_BYTE;
		else
		begin
			if (do_write && !is_disp && eff_addr == dmsic_pkg::ADDR_FLAGS_REGISTER)
				flags_register[3:0] <= next_byte[3:0] & dmsic_pkg::FLAGS_SW_MASK[3:0];
			else if (alu_in)
				flags_register[3:0] <= alu_flags;
			if (halt_op_in)
				flags_register[dmsic_pkg::FLAG_HALTED] <= 1'b1;
			else if (dog_clear_op_in)
				flags_register[dmsic_pkg::FLAG_HALTED] <= 1'b0;
			if (dog_timeout_in)
				flags_register[dmsic_pkg::FLAG_DOG] <= 1'b1;
			else if (dog_clear_op_in || halt_op_in)
				flags_register[dmsic_pkg::FLAG_DOG] <= 1'b0;
			flags_register[7:6] <= 2'b00;
		end
	end

	// external request pin passes two flops; third stage feeds the edge detect
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
			ext_s3 <= 1'b1;
		end
		else
		begin
			ext_s1 <= ext_irq_n_in;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end
	assign ext_fall = ext_s3 && !ext_s2;

	// pending and enabled sources; full stack holds off acknowledge
	always_comb
	begin
		pend[0] = irq_control_0[dmsic_pkg::IRQ0_EXT_FLAG] & irq_control_0[dmsic_pkg::IRQ0_EXT_EN];
		pend[1] = irq_control_0[dmsic_pkg::IRQ0_TB_FLAG] & irq_control_0[dmsic_pkg::IRQ0_TB_EN];
		pend[2] = irq_control_0[dmsic_pkg::IRQ0_RTC_FLAG] & irq_control_0[dmsic_pkg::IRQ0_RTC_EN];
		pend[3] = irq_control_1[dmsic_pkg::IRQ1_TMR_FLAG] & irq_control_1[dmsic_pkg::IRQ1_TMR_EN];
		ack = ack_ready_in && irq_control_0[dmsic_pkg::IRQ0_GLOBAL_EN] && (pend != 4'h0)
			&& (stack_depth_in < dmsic_pkg::STACK_LEVELS);
		next_vector = dmsic_pkg::VEC_TMR;
		if (pend[0])
			next_vector = dmsic_pkg::VEC_EXT;
		else if (pend[1])
			next_vector = dmsic_pkg::VEC_TB;
		else if (pend[2])
			next_vector = dmsic_pkg::VEC_RTC;
	end

	// only the counter is pushed by the pipeline; status stays put
	assign ack_out = ack;
	assign vector_out = next_vector;

	// interrupt control: set wins over a software clear in the same cycle
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			irq_control_0 <= dmsic_pkg::RESET_BYTE;
			irq_control_1 <= dmsic_pkg::RESET_BYTE;
		end
		else
		begin
			if (do_write && !is_disp && eff_addr == dmsic_pkg::ADDR_IRQ_CONTROL_0)
				irq_control_0 <= next_byte & dmsic_pkg::IRQ0_MASK;
			if (do_write && !is_disp && eff_addr == dmsic_pkg::ADDR_IRQ_CONTROL_1)
				irq_control_1 <= next_byte & dmsic_pkg::IRQ1_MASK;
			if (ack)
			begin
				irq_control_0[dmsic_pkg::IRQ0_GLOBAL_EN] <= 1'b0;
				if (pend[0])
					irq_control_0[dmsic_pkg::IRQ0_EXT_FLAG] <= 1'b0;
				else if (pend[1])
					irq_control_0[dmsic_pkg::IRQ0_TB_FLAG] <= 1'b0;
				else if (pend[2])
					irq_control_0[dmsic_pkg::IRQ0_RTC_FLAG] <= 1'b0;
				else
					irq_control_1[dmsic_pkg::IRQ1_TMR_FLAG] <= 1'b0;
			end
			else if (irq_return_op_in)
				irq_control_0[dmsic_pkg::IRQ0_GLOBAL_EN] <= 1'b1;
			// requests latch even while blocked
			if (ext_fall)
				irq_control_0[dmsic_pkg::IRQ0_EXT_FLAG] <= 1'b1;
			if (tb_tick_in)
				irq_control_0[dmsic_pkg::IRQ0_TB_FLAG] <= 1'b1;
			if (rtc_tick_in)
				irq_control_0[dmsic_pkg::IRQ0_RTC_FLAG] <= 1'b1;
			if (tmr_tick_in)
				irq_control_1[dmsic_pkg::IRQ1_TMR_FLAG] <= 1'b1;
		end
	end

	// any source event wakes a halted device
	assign wake_out = flags_register[dmsic_pkg::FLAG_HALTED]
		&& (ext_fall || tb_tick_in || rtc_tick_in || tmr_tick_in);

	assign rdata_out = cur_byte;
	assign zero_out = flags_register[dmsic_pkg::FLAG_ZERO];
	assign work_register_out = work_register;
	assign halted_out = flags_register[dmsic_pkg::FLAG_HALTED];
endmodule : dmsic_core
`default_nettype wire

// *** design/dmsic_pkg.sv ***
// package: data-side core map, field layout, opcodes and constants
package dmsic_pkg;
	localparam logic [7:0] ADDR_INDIRECT_0 = 8'h00;
	localparam logic [7:0] ADDR_MEM_POINTER_0 = 8'h01;
	localparam logic [7:0] ADDR_INDIRECT_1 = 8'h02;
	localparam logic [7:0] ADDR_MEM_POINTER_1 = 8'h03;
	localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
	localparam logic [7:0] ADDR_WORK_REGISTER = 8'h05;
	localparam logic [7:0] ADDR_PROG_COUNT_LOW = 8'h06;
	localparam logic [7:0] ADDR_LOOKUP_POINTER = 8'h07;
	localparam logic [7:0] ADDR_LOOKUP_HIGH_BYTE = 8'h08;
	localparam logic [7:0] ADDR_CLOCK_TICK_CONTROL = 8'h09;
	localparam logic [7:0] ADDR_FLAGS_REGISTER = 8'h0a;
	localparam logic [7:0] ADDR_IRQ_CONTROL_0 = 8'h0b;
	localparam logic [7:0] ADDR_IO_PORT_A = 8'h12;
	localparam logic [7:0] ADDR_IO_PORT_B = 8'h14;
	localparam logic [7:0] ADDR_IRQ_CONTROL_1 = 8'h1e;
	localparam logic [7:0] ADDR_TIMER_A_COUNT_HIGH = 8'h20;
	localparam logic [7:0] ADDR_TIMER_A_COUNT_LOW = 8'h21;
	localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h22;
	localparam logic [7:0] ADDR_TIMER_B_COUNT_HIGH = 8'h23;
	localparam logic [7:0] ADDR_TIMER_B_COUNT_LOW = 8'h24;
	localparam logic [7:0] ADDR_RC_CONVERTER_CONTROL = 8'h25;
	localparam logic [7:0] ADDR_GP_FIRST = 8'h40;
	localparam logic [7:0] ADDR_GP_LAST = 8'h7f;
	localparam int GP_DEPTH = 64;
	// display memory window reached only through pointer 1
	localparam logic [7:0] ADDR_DISP_FIRST = 8'h40;
	localparam logic [7:0] ADDR_DISP_LAST = 8'h53;
	// flags_register fields
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_HALF = 1;
	localparam int FLAG_ZERO = 2;
	localparam int FLAG_WRAP = 3;
	localparam int FLAG_HALTED = 4;
	localparam int FLAG_DOG = 5;
	localparam logic [7:0] FLAGS_SW_MASK = 8'h0f;
	// irq_control_0 / irq_control_1 fields
	localparam int IRQ0_GLOBAL_EN = 0;
	localparam int IRQ0_EXT_EN = 1;
	localparam int IRQ0_TB_EN = 2;
	localparam int IRQ0_RTC_EN = 3;
	localparam int IRQ0_EXT_FLAG = 4;
	localparam int IRQ0_TB_FLAG = 5;
	localparam int IRQ0_RTC_FLAG = 6;
	localparam int IRQ1_TMR_EN = 0;
	localparam int IRQ1_TMR_FLAG = 4;
	localparam logic [7:0] IRQ0_MASK = 8'h7f;
	localparam logic [7:0] IRQ1_MASK = 8'h11;
	localparam logic [10:0] VEC_EXT = 11'h004;
	localparam logic [10:0] VEC_TB = 11'h008;
	localparam logic [10:0] VEC_RTC = 11'h00c;
	localparam logic [10:0] VEC_TMR = 11'h010;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [2:0] STACK_LEVELS = 3'h4;
	// arithmetic unit operation codes
	typedef enum logic [3:0] {
		DMSIC_OP_ADD = 4'b0000,
		DMSIC_OP_ADC = 4'b0001,
		DMSIC_OP_SUB = 4'b0010,
		DMSIC_OP_SBC = 4'b0011,
		DMSIC_OP_DAA = 4'b0100,
		DMSIC_OP_AND = 4'b0101,
		DMSIC_OP_OR = 4'b0110,
		DMSIC_OP_XOR = 4'b0111,
		DMSIC_OP_CPL = 4'b1000,
		DMSIC_OP_RL = 4'b1001,
		DMSIC_OP_RR = 4'b1010,
		DMSIC_OP_RLC = 4'b1011,
		DMSIC_OP_RRC = 4'b1100,
		DMSIC_OP_INC = 4'b1101,
		DMSIC_OP_DEC = 4'b1110,
		DMSIC_OP_PASS = 4'b1111
	} dmsic_op_t;
endpackage : dmsic_pkg

// *** design/dmsic_alu.sv ***
// arithmetic unit: 8-bit result and four status flags
`timescale 1ns/1ps
`default_nettype none
module dmsic_alu (
	input wire dmsic_pkg::dmsic_op_t op_in,
	input wire logic [7:0] a_in,
	input wire logic [7:0] b_in,
	input wire logic carry_in,
	input wire logic [3:0] flags_in,
	output logic [7:0] result_out,
	output logic [3:0] flags_out,
	output logic arith_out
);
	logic [8:0] sum;
	logic [4:0] low;
	logic [7:0] bx;
	logic cin;
	logic sub;
	logic [7:0] adj;
	// one adder serves add and subtract; subtract adds the inverted operand
	always_comb
	begin
		sub = (op_in == dmsic_pkg::DMSIC_OP_SUB) || (op_in == dmsic_pkg::DMSIC_OP_SBC);
		bx = sub ? ~b_in : b_in;
		cin = 1'b0;
		if (op_in == dmsic_pkg::DMSIC_OP_ADC || op_in == dmsic_pkg::DMSIC_OP_SBC)
			cin = carry_in;
		else if (op_in == dmsic_pkg::DMSIC_OP_SUB)
			cin = 1'b1;
		sum = {1'b0, a_in} + {1'b0, bx} + {8'h00, cin};
		low = {1'b0, a_in[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
		adj = 8'h00;
		if (a_in[3:0] > 4'h9 || flags_in[dmsic_pkg::FLAG_HALF])
			adj[3:0] = 4'h6;
		if (a_in > 8'h99 || flags_in[dmsic_pkg::FLAG_CARRY])
			adj[7:4] = 4'h6;
		flags_out = flags_in;
		arith_out = 1'b1;
		result_out = a_in;
		case (op_in)
			dmsic_pkg::DMSIC_OP_ADD, dmsic_pkg::DMSIC_OP_ADC,
			dmsic_pkg::DMSIC_OP_SUB, dmsic_pkg::DMSIC_OP_SBC:
			begin
				result_out = sum[7:0];
				flags_out[dmsic_pkg::FLAG_CARRY] = sum[8];
				flags_out[dmsic_pkg::FLAG_HALF] = low[4];
				flags_out[dmsic_pkg::FLAG_WRAP] = (a_in[7] == bx[7]) && (sum[7] != a_in[7]);
			end
			dmsic_pkg::DMSIC_OP_DAA:
			begin
				sum = {1'b0, a_in} + {1'b0, adj};
				result_out = sum[7:0];
				flags_out[dmsic_pkg::FLAG_CARRY] = sum[8] | flags_in[dmsic_pkg::FLAG_CARRY];
			end
			dmsic_pkg::DMSIC_OP_AND: result_out = a_in & b_in;
			dmsic_pkg::DMSIC_OP_OR: result_out = a_in | b_in;
			dmsic_pkg::DMSIC_OP_XOR: result_out = a_in ^ b_in;
			dmsic_pkg::DMSIC_OP_CPL: result_out = ~a_in;
			dmsic_pkg::DMSIC_OP_INC: result_out = a_in + 8'h01;
			dmsic_pkg::DMSIC_OP_DEC: result_out = a_in - 8'h01;
			// rotates leave zero alone
			dmsic_pkg::DMSIC_OP_RL:
			begin
				result_out = {a_in[6:0], a_in[7]};
				arith_out = 1'b0;
			end
			dmsic_pkg::DMSIC_OP_RR:
			begin
				result_out = {a_in[0], a_in[7:1]};
				arith_out = 1'b0;
			end
			dmsic_pkg::DMSIC_OP_RLC:
			begin
				result_out = {a_in[6:0], carry_in};
				flags_out[dmsic_pkg::FLAG_CARRY] = a_in[7];
				arith_out = 1'b0;
			end
			dmsic_pkg::DMSIC_OP_RRC:
			begin
				result_out = {carry_in, a_in[7:1]};
				flags_out[dmsic_pkg::FLAG_CARRY] = a_in[0];
				arith_out = 1'b0;
			end
			default:
			begin
				result_out = a_in;
				arith_out = 1'b0;
			end
		endcase
		if (arith_out)
			flags_out[dmsic_pkg::FLAG_ZERO] = (result_out == 8'h00);
	end
endmodule : dmsic_alu
`default_nettype wire

// *** sim/dmsic_core_asserts.sv ***
// checker: port-level properties of the data-side core
`timescale 1ns/1ps
`default_nettype none
module dmsic_core_asserts (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] addr_in,
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	input wire logic [7:0] rdata_out,
	input wire logic halt_op_in,
	input wire logic dog_clear_op_in,
	input wire logic halted_out,
	input wire logic zero_out,
	input wire logic [7:0] work_register_out,
	input wire logic [2:0] stack_depth_in,
	input wire logic ack_ready_in,
	input wire logic ack_out,
	input wire logic [10:0] vector_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// map holes, storage write-back and mirrored registers, seen through the read port
	a_reserved_zero: assert property (addr_in inside {[8'h0c:8'h11], 8'h13,
		[8'h15:8'h1d], 8'h1f, [8'h26:8'h3f]} |-> rdata_out == 8'h00) else $error("hole not zero");
	a_gp_write_back: assert property (wr_in && addr_in inside {[8'h40:8'h7f]}
		##1 !wr_in && $stable(addr_in) |-> rdata_out == $past(wdata_in)) else $error("byte lost");
	a_work_mapped: assert property (addr_in == 8'h05 |->
		rdata_out == work_register_out) else $error("work view differs");
	a_status_view: assert property (addr_in == 8'h0a |-> rdata_out[7:6] == 2'b00 &&
		rdata_out[2] == zero_out && rdata_out[4] == halted_out) else $error("status view bad");
	// halt flag only moves on its own events
	a_halt_sets: assert property (halt_op_in |=> halted_out) else $error("halt not set");
	a_dog_clears: assert property (dog_clear_op_in && !halt_op_in |=> !halted_out)
		else $error("halt not cleared");
	a_halt_kept: assert property (wr_in && addr_in == 8'h0a && !halt_op_in &&
		!dog_clear_op_in |=> $stable(halted_out)) else $error("halt flag written");
	// acknowledge gating and one-shot behaviour
	a_ack_gated: assert property (ack_out |-> ack_ready_in && stack_depth_in < 3'h4)
		else $error("ack while blocked");
	a_ack_once: assert property (ack_out && !wr_in |=> !ack_out) else $error("ack repeats");
	a_vector_fixed: assert property (ack_out |-> vector_out inside {11'h004, 11'h008,
		11'h00c, 11'h010}) else $error("bad vector");
	c_ack: cover property (ack_out);
	c_full: cover property (ack_ready_in && stack_depth_in == 3'h4);
	c_halt: cover property (halt_op_in);
endmodule : dmsic_core_asserts
bind dmsic_core dmsic_core_asserts u_asserts (.clk_in, .rst_n_in, .addr_in, .wr_in, .wdata_in,
	.rdata_out, .halt_op_in, .dog_clear_op_in, .halted_out, .zero_out, .work_register_out,
	.stack_depth_in, .ack_ready_in, .ack_out, .vector_out);
`default_nettype wire

// *** sim/dmsic_disp_model.sv ***
// far-side model: display segment memory behind pointer 1
`timescale 1ns/1ps
`default_nettype none
module dmsic_disp_model (
	input wire logic clk_in,
	input wire logic wr_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] seg [0:127];
	// store on strobe; unwritten cells stay unknown on purpose
	always_ff @(posedge clk_in)
	begin
		if (wr_in)
		begin
			seg[addr_in[6:0]] <= wdata_in;
		end
	end
	assign rdata_out = seg[addr_in[6:0]];
endmodule : dmsic_disp_model
`default_nettype wire

// *** sim/tb_top.sv ***
// testbench: directed and random traffic through the data-side core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_in, rst_n_in, rd_in, ack_ready_in, ext_irq_n_in, disp_wr_out;
	logic zero_out, halted_out, ack_out, wake_out;
	logic [7:0] addr_in, wdata_in, rdata_out, work_register_out, disp_addr_out;
	logic [7:0] disp_wdata_out, disp_rdata_in, seed, a, ev;
	logic [11:0] e;
	logic [10:0] vector_out;
	logic [2:0] stack_depth_in;
	logic [3:0] kind;
	logic [7:0] gp [0:63];
	logic [7:0] al [0:11];
	int miscompares, check_count, cyc;
	// kind: 1 write, 2 alu to work, 3 work load, 4 bit op, 5 alu to memory, 6 lookup load
	dmsic_core uut (.clk_in, .rst_n_in, .addr_in, .rd_in, .wr_in(kind == 4'h1), .wdata_in,
		.rdata_out, .bit_op_in(kind == 4'h4), .bit_sel_in(wdata_in[2:0]),
		.bit_val_in(wdata_in[3]), .alu_in(kind == 4'h2 || kind == 4'h5),
		.alu_op_in(dmsic_pkg::dmsic_op_t'(wdata_in[3:0])), .alu_to_mem_in(kind == 4'h5),
		.zero_out, .work_load_in(kind == 4'h3), .work_data_in(wdata_in), .work_register_out,
		.disp_wr_out, .disp_addr_out, .disp_wdata_out, .disp_rdata_in, .halt_op_in(ev[0]),
		.dog_clear_op_in(ev[1]), .dog_timeout_in(ev[2]), .halted_out, .stack_depth_in,
		.irq_return_op_in(ev[6]), .sub_return_op_in(ev[7]), .ack_ready_in, .ack_out,
		.vector_out, .wake_out, .ext_irq_n_in, .tb_tick_in(ev[3]), .rtc_tick_in(ev[4]),
		.tmr_tick_in(ev[5]), .lookup_load_in(kind == 4'h6), .lookup_data_in(wdata_in));
	dmsic_disp_model u_disp (.clk_in, .wr_in(disp_wr_out), .addr_in(disp_addr_out),
		.wdata_in(disp_wdata_out), .rdata_out(disp_rdata_in));
	// clock at 200 MHz
	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	// hang guard, well above the directed sequence length
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// expected add: {wrap, zero, half, carry, sum}
	function automatic logic [11:0] add_exp(input logic [7:0] x, input logic [7:0] y);
		logic [8:0] s;
		logic h;
		logic v;
		s = x + y;
		h = (x[3:0] + y[3:0]) > 5'h0f;
		v = (x[7] == y[7]) && (s[7] != x[7]);
		return {v, s[7:0] == 8'h00, h, s[8], s[7:0]};
	endfunction : add_exp
	task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
		check_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// one-cycle operation strobe, then a quiet edge
	task automatic act(input logic [3:0] k, input logic [7:0] ad, input logic [7:0] d);
		@(posedge clk_in);
		kind <= k;
		addr_in <= ad;
		wdata_in <= d;
		@(posedge clk_in);
		kind <= 4'h0;
	endtask : act
	task automatic rchk(input logic [7:0] ad, input logic [7:0] x);
		@(posedge clk_in);
		addr_in <= ad;
		rd_in <= 1'b1;
		@(negedge clk_in);
		chk("rdata", {3'h0, rdata_out}, {3'h0, x});
		// qualifier released on the rising edge, never mid-cycle
		@(posedge clk_in);
		rd_in <= 1'b0;
	endtask : rchk
	task automatic pulse(input logic [7:0] m);
		@(posedge clk_in);
		ev <= m;
		@(posedge clk_in);
		ev <= 8'h00;
	endtask : pulse
	task automatic ackchk(input logic [10:0] v);
		@(posedge clk_in);
		ack_ready_in <= 1'b1;
		#1;
		chk("ack", {10'h000, ack_out}, 11'h001);
		chk("vector", vector_out, v);
		@(posedge clk_in);
		ack_ready_in <= 1'b0;
	endtask : ackchk
	task automatic end_of_test();
		if (miscompares == 0 && check_count > 0)
		begin
			$display("Run complete: PASS");
		end
		else
		begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	// main sequence
	initial
	begin
		rst_n_in = 1'b0;
		rd_in = 1'b0;
		ack_ready_in = 1'b0;
		ext_irq_n_in = 1'b1;
		kind = 4'h0;
		ev = 8'h00;
		addr_in = 8'h00;
		wdata_in = 8'h00;
		stack_depth_in = 3'h0;
		seed = 8'h63;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		rchk(8'h0b, 8'h00);
		act(4'h1, 8'h30, 8'hff);
		rchk(8'h30, 8'h00);
		act(4'h1, 8'h08, 8'hff);
		act(4'h6, 8'h00, 8'hc3);
		rchk(8'h08, 8'hc3);
		pulse(8'h04);
		rchk(8'h0a, 8'h20);
		pulse(8'h01);
		rchk(8'h0a, 8'h10);
		act(4'h1, 8'h0a, 8'hff);
		rchk(8'h0a, 8'h1f);
		pulse(8'h02);
		rchk(8'h0a, 8'h0f);
		for (int i = 0; i < 12; i++)
		begin
			seed = lfsr(seed);
			al[i] = {2'b01, seed[5:0]};
			seed = lfsr(seed);
			gp[seed[7:2] ^ al[i][5:0] ^ seed[7:2]] = seed;
			act(4'h1, al[i], seed);
		end
		for (int i = 0; i < 12; i++)
		begin
			rchk(al[i], gp[al[i][5:0]]);
		end
		act(4'h1, 8'h01, 8'h45);
		act(4'h1, 8'h00, 8'h3c);
		rchk(8'h45, 8'h3c);
		act(4'h1, 8'h03, 8'h46);
		act(4'h1, 8'h02, 8'h11);
		rchk(8'h02, 8'h11);
		act(4'h1, 8'h01, 8'h02);
		rchk(8'h00, 8'h00);
		act(4'h1, 8'h00, 8'h77);
		rchk(8'h02, 8'h11);
		act(4'h1, 8'h01, 8'hc5);
		rchk(8'h00, 8'h00);
		act(4'h1, 8'h03, 8'h81);
		act(4'h1, 8'h02, 8'ha5);
		rchk(8'h02, 8'ha5);
		chk("disp_addr", {3'h0, disp_addr_out}, 11'h001);
		act(4'h1, 8'h05, 8'h96);
		rchk(8'h05, 8'h96);
		act(4'h1, 8'h42, 8'h00);
		act(4'h4, 8'h42, 8'h0d);
		rchk(8'h42, 8'h20);
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			a = (i == 0) ? 8'h7f : lfsr(seed);
			seed = (i == 0) ? 8'h01 : seed;
			e = add_exp(a, seed);
			act(4'h1, 8'h41, a);
			act(4'h3, 8'h41, seed);
			act(4'h2, 8'h41, 8'h00);
			rchk(8'h05, e[7:0]);
			rchk(8'h0a, {4'h0, e[11:8]});
		end
		act(4'h1, 8'h41, 8'h5a);
		act(4'h3, 8'h41, 8'h5a);
		act(4'h2, 8'h41, 8'h02);
		rchk(8'h0a, 8'h07);
		act(4'h5, 8'h41, 8'h0d);
		rchk(8'h41, 8'h5b);
		// rotate through carry, then subtract with a pending borrow
		act(4'h2, 8'h41, 8'h0b);
		rchk(8'h05, 8'hb7);
		rchk(8'h0a, 8'h02);
		act(4'h2, 8'h41, 8'h03);
		rchk(8'h05, 8'ha3);
		rchk(8'h0a, 8'h0a);
		act(4'h1, 8'h0b, 8'h0e);
		ext_irq_n_in <= 1'b0;
		pulse(8'h18);
		repeat (4) @(posedge clk_in);
		rchk(8'h0b, 8'h7e);
		@(posedge clk_in);
		stack_depth_in <= 3'h4;
		ack_ready_in <= 1'b1;
		act(4'h1, 8'h0b, 8'h7f);
		@(negedge clk_in);
		chk("ack", {10'h000, ack_out}, 11'h000);
		@(posedge clk_in);
		ack_ready_in <= 1'b0;
		stack_depth_in <= 3'h3;
		ackchk(dmsic_pkg::VEC_EXT);
		rchk(8'h0b, 8'h6e);
		pulse(8'h40);
		rchk(8'h0b, 8'h6f);
		ackchk(dmsic_pkg::VEC_TB);
		pulse(8'h80);
		rchk(8'h0b, 8'h4e);
		pulse(8'h40);
		ackchk(dmsic_pkg::VEC_RTC);
		act(4'h1, 8'h1e, 8'h01);
		pulse(8'h20);
		rchk(8'h1e, 8'h11);
		act(4'h1, 8'h0b, 8'h01);
		ackchk(dmsic_pkg::VEC_TMR);
		// a tick wakes the core only while it is halted
		@(posedge clk_in);
		ev <= 8'h20;
		@(negedge clk_in);
		chk("wake", {10'h000, wake_out}, 11'h000);
		@(posedge clk_in);
		ev <= 8'h01;
		@(posedge clk_in);
		ev <= 8'h20;
		@(negedge clk_in);
		chk("wake", {10'h000, wake_out}, 11'h001);
		@(posedge clk_in);
		ev <= 8'h00;
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
